// ---- lhsd_pkg.sv ----
// Purpose: Shared constants and carriers for the host-select and duty block
// Assumes: One 25 MHz clock, asynchronous active-low reset
// Notes: Instruction field positions follow the host instruction byte layout
package lhsd_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned POR_TIME_US = 10;
  localparam int unsigned POR_CYCLES = (POR_TIME_US * (CLK_HZ / 1000000));
  localparam int unsigned POR_W = 9;

  // Instruction opcode detection
  localparam logic [7:0] OP_FUNC_MASK = 8'hE0;
  localparam logic [7:0] OP_FUNC_VAL = 8'h20;
  localparam logic [7:0] OP_EXT_MASK = 8'hF8;
  localparam logic [7:0] OP_EXT_VAL = 8'h08;
  localparam logic [7:0] OP_SHEN_MASK = 8'hF0;
  localparam logic [7:0] OP_SHEN_VAL = 8'h10;
  localparam logic [7:0] OP_BID_MASK = 8'hFE;
  localparam logic [7:0] OP_BID_VAL = 8'h06;

  // Field positions
  localparam int unsigned FS_IF_BIT = 4;
  localparam int unsigned FS_RE_BIT = 2;
  localparam int unsigned FS_DC_BIT = 1;
  localparam int unsigned FS_REV_BIT = 0;
  localparam int unsigned EX_FW_BIT = 2;
  localparam int unsigned EX_NW_BIT = 0;
  localparam int unsigned BID_BIT = 0;

  // Display geometry
  localparam logic [5:0] DUTY_2LINE = 6'h11;
  localparam logic [5:0] DUTY_4LINE = 6'h21;
  localparam logic [4:0] CHARS_WIDE = 5'h10;
  localparam logic [4:0] CHARS_NARROW = 5'h0D;
  localparam logic [6:0] ICON_MAX = 7'h50;

  // Reset values
  localparam logic RST_IF = 1'b1;
  localparam logic RST_RE = 1'b0;
  localparam logic RST_DC = 1'b0;
  localparam logic RST_REV = 1'b0;
  localparam logic RST_NW = 1'b0;
  localparam logic RST_FW = 1'b0;
  localparam logic RST_BID = 1'b0;
  localparam logic [3:0] RST_SHEN = 4'h0;

  typedef enum logic [1:0] {
    LHSD_OP_INST_WR = 2'b00,
    LHSD_OP_BUSY_RD = 2'b01,
    LHSD_OP_DATA_WR = 2'b10,
    LHSD_OP_DATA_RD = 2'b11
  } lhsd_op_t;

  typedef struct packed {
    logic four_line_select;
    logic font_width_select;
    logic eight_bit;
    logic reverse_all;
    logic seg_reverse;
    logic line_shift_mode;
    logic [3:0] line_shift_en;
  } lhsd_cfg_t;

  typedef struct packed {
    logic [5:0] duty_div;
    logic [2:0] lines;
    logic [4:0] chars_per_line;
    logic [6:0] icons;
  } lhsd_geom_t;

endpackage

// ---- lhsd_host_select.sv ----
// Purpose: Host port mode selection, register routing and display geometry
// Assumes: Host pins already synchronous to i_clk; serial framing decoded elsewhere
// Notes: Osc source choice is a pad matter; this logic sees one clock

//////////////////////////////////////////////////////////////////////////////
module lhsd_host_select #(
  parameter int unsigned POR_COUNT = lhsd_pkg::POR_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_reset_n,
  input wire logic i_interface_select,
  input wire logic i_par_strobe,
  input wire logic i_par_register_select,
  input wire logic i_par_read,
  input wire logic [7:0] i_par_data,
  input wire logic i_ser_strobe,
  input wire logic i_ser_register_select,
  input wire logic i_ser_read,
  input wire logic [7:0] i_ser_data,
  input wire logic i_busy,
  input wire logic [6:0] i_addr_counter,
  input wire logic [7:0] i_ram_rdata,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_data,
  output logic o_data_wr,
  output logic o_data_rd,
  output logic [7:0] o_data_hold,
  output logic [7:0] o_rd_data,
  output logic o_parallel_mode,
  output logic o_core_reset,
  output lhsd_pkg::lhsd_cfg_t o_cfg,
  output lhsd_pkg::lhsd_geom_t o_geom
);
  import lhsd_pkg::*;

  logic sel_strobe;
  logic sel_rs;
  logic sel_read;
  logic [7:0] sel_data;
  lhsd_op_t op;
  logic [POR_W-1:0] por_reg;
  logic por_active;
  logic cfg_rst;
  logic re_reg;
  lhsd_cfg_t cfg_reg;
  logic [7:0] cmd;
  logic take_cmd;

  //////////////////////////////////////////////////////////////////////////////
  // Power-on and pin reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      por_reg <= '0;
    else if (por_active)
      por_reg <= por_reg + POR_W'(1);
  end

  assign por_active = (por_reg < POR_W'(POR_COUNT));
  // Pin reset held synchronous so a glitch-free release needs no extra stage
  assign cfg_rst = por_active || !i_ext_reset_n;
  assign o_core_reset = cfg_rst;

  //////////////////////////////////////////////////////////////////////////////
  // Host port selection
  always_comb
  begin
    if (i_interface_select)
    begin
      sel_strobe = i_par_strobe;
      sel_rs = i_par_register_select;
      sel_read = i_par_read;
      sel_data = i_par_data;
    end
    else
    begin
      sel_strobe = i_ser_strobe;
      sel_rs = i_ser_register_select;
      sel_read = i_ser_read;
      sel_data = i_ser_data;
    end
  end

  assign o_parallel_mode = i_interface_select;
  assign op = lhsd_op_t'({sel_rs, sel_read});
  // Accesses during reset are dropped; host must wait for ready anyway
  assign take_cmd = sel_strobe && !cfg_rst && (op == LHSD_OP_INST_WR);
  assign cmd = sel_data;

  //////////////////////////////////////////////////////////////////////////////
  // Transfer routing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmd_valid <= 1'b0;
      o_cmd_data <= 8'h00;
      o_data_wr <= 1'b0;
      o_data_rd <= 1'b0;
      o_data_hold <= 8'h00;
      o_rd_data <= 8'h00;
    end
    else
    begin
      o_cmd_valid <= take_cmd;
      o_data_wr <= 1'b0;
      o_data_rd <= 1'b0;
      if (take_cmd)
        o_cmd_data <= cmd;
      if (sel_strobe && !cfg_rst)
      begin
        unique case (op)
          LHSD_OP_INST_WR: ;
          LHSD_OP_BUSY_RD: o_rd_data <= {i_busy, i_addr_counter};
          LHSD_OP_DATA_WR:
          begin
            o_data_hold <= sel_data;
            o_data_wr <= 1'b1;
          end
          LHSD_OP_DATA_RD:
          begin
            o_rd_data <= o_data_hold;
            o_data_rd <= 1'b1;
          end
        endcase
      end
      else if (o_data_rd)
        o_data_hold <= i_ram_rdata; // Prefetch next address after a read
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction-held configuration
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      re_reg <= RST_RE;
      cfg_reg <= '{four_line_select: RST_NW, font_width_select: RST_FW,
                   eight_bit: RST_IF, reverse_all: RST_REV, seg_reverse: RST_BID,
                   line_shift_mode: RST_DC, line_shift_en: RST_SHEN};
    end
    else if (cfg_rst)
    begin
      re_reg <= RST_RE;
      cfg_reg <= '{four_line_select: RST_NW, font_width_select: RST_FW,
                   eight_bit: RST_IF, reverse_all: RST_REV, seg_reverse: RST_BID,
                   line_shift_mode: RST_DC, line_shift_en: RST_SHEN};
    end
    else if (take_cmd)
    begin
      if ((cmd & OP_FUNC_MASK) == OP_FUNC_VAL)
      begin
        re_reg <= cmd[FS_RE_BIT];
        cfg_reg.eight_bit <= cmd[FS_IF_BIT];
        if (!cmd[FS_RE_BIT])
        begin
          cfg_reg.line_shift_mode <= cmd[FS_DC_BIT];
          cfg_reg.reverse_all <= cmd[FS_REV_BIT];
        end
      end
      else if (re_reg && ((cmd & OP_EXT_MASK) == OP_EXT_VAL))
      begin
        cfg_reg.four_line_select <= cmd[EX_NW_BIT];
        cfg_reg.font_width_select <= cmd[EX_FW_BIT];
      end
      else if (re_reg && cfg_reg.line_shift_mode && ((cmd & OP_SHEN_MASK) == OP_SHEN_VAL))
        cfg_reg.line_shift_en <= cmd[3:0];
      else if (re_reg && ((cmd & OP_BID_MASK) == OP_BID_VAL))
        cfg_reg.seg_reverse <= cmd[BID_BIT];
    end
  end

  assign o_cfg = cfg_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Geometry from line count and font width
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_geom <= '{duty_div: DUTY_2LINE, lines: 3'd2, chars_per_line: CHARS_WIDE,
                  icons: ICON_MAX};
    else if (!cfg_reg.four_line_select)
      o_geom <= '{duty_div: DUTY_2LINE, lines: 3'd2, chars_per_line: CHARS_WIDE,
                  icons: ICON_MAX};
    else if (!cfg_reg.font_width_select)
      o_geom <= '{duty_div: DUTY_4LINE, lines: 3'd4, chars_per_line: CHARS_WIDE,
                  icons: ICON_MAX};
    else
      o_geom <= '{duty_div: DUTY_4LINE, lines: 3'd4, chars_per_line: CHARS_NARROW,
                  icons: ICON_MAX};
  end

  // Single clock in; osc_in or the internal oscillator is chosen at the pad

endmodule

// ---- lhsd_chk.sv ----
// Purpose: Port assertions for the host-select block
// Assumes: One clock domain, POR_COUNT matches the bound instance
// Notes: Sees top-module ports only
module lhsd_chk
  import lhsd_pkg::*;
#(
  parameter int unsigned POR_COUNT = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_reset_n,
  input wire logic i_interface_select,
  input wire logic i_par_strobe,
  input wire logic i_par_register_select,
  input wire logic i_par_read,
  input wire logic [7:0] i_par_data,
  input wire logic i_ser_strobe,
  input wire logic i_ser_register_select,
  input wire logic i_ser_read,
  input wire logic [7:0] i_ser_data,
  input wire logic i_busy,
  input wire logic [6:0] i_addr_counter,
  input wire logic o_cmd_valid,
  input wire logic [7:0] o_cmd_data,
  input wire logic o_data_wr,
  input wire logic o_data_rd,
  input wire logic [7:0] o_data_hold,
  input wire logic [7:0] o_rd_data,
  input wire logic o_parallel_mode,
  input wire logic o_core_reset,
  input wire lhsd_pkg::lhsd_cfg_t o_cfg,
  input wire lhsd_pkg::lhsd_geom_t o_geom
);
  wire logic stb = i_interface_select ? i_par_strobe : i_ser_strobe;
  wire logic rs = i_interface_select ? i_par_register_select : i_ser_register_select;
  wire logic rd = i_interface_select ? i_par_read : i_ser_read;
  wire logic [7:0] dat = i_interface_select ? i_par_data : i_ser_data;
  wire logic take = stb && !o_core_reset;
  wire logic nw = o_cfg.four_line_select;
  wire logic fw = o_cfg.font_width_select;
  logic [15:0] cnt;
  // Counts the power-on window independently of the design
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt <= 16'h0;
    else if (cnt < POR_COUNT)
      cnt <= cnt + 16'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_mode_follow: assert property (o_parallel_mode == i_interface_select)
    else $error("parallel mode differs from select");
  chk_cmd_route: assert property (take && !rs && !rd |=> o_cmd_valid && o_cmd_data == $past(dat))
    else $error("command write not routed");
  chk_data_write: assert property (take && rs && !rd |=> o_data_wr && o_data_hold == $past(dat))
    else $error("data write not routed");
  chk_busy_read: assert property (take && !rs && rd |=> o_rd_data == {$past(i_busy), $past(i_addr_counter)})
    else $error("busy read wrong");
  chk_data_read: assert property (take && rs && rd |=> o_data_rd && o_rd_data == $past(o_data_hold))
    else $error("data read wrong");
  chk_refuse_reset: assert property (stb && o_core_reset |=> !(o_cmd_valid || o_data_wr || o_data_rd))
    else $error("access taken in reset");
  chk_geom_map: assert property (o_geom == {$past(nw) ? DUTY_4LINE : DUTY_2LINE, $past(nw) ? 3'h4 : 3'h2,
    ($past(nw) && $past(fw)) ? CHARS_NARROW : CHARS_WIDE, ICON_MAX})
    else $error("geometry wrong");
  chk_ext_default: assert property (!i_ext_reset_n |=> o_cfg == {RST_NW, RST_FW, RST_IF, RST_REV,
    RST_BID, RST_DC, RST_SHEN})
    else $error("config not defaulted");
  chk_por_hold: assert property (cnt < POR_COUNT |-> o_core_reset)
    else $error("power-on reset too short");
  chk_por_end: assert property ($rose(cnt == POR_COUNT) && i_ext_reset_n && $past(i_ext_reset_n) |-> !o_core_reset)
    else $error("power-on reset too long");
  cover property (take && rs && rd);
  cover property (o_geom.chars_per_line == CHARS_NARROW);
  cover property (!i_ext_reset_n && stb);
endmodule
//////////////////////////////////////////////////////////////////////////////
bind lhsd_host_select lhsd_chk #(.POR_COUNT(POR_COUNT)) lhsd_chk_inst (.*);

// ---- lhsd_host_model.sv ----
// Purpose: Host processor model for both host ports
// Assumes: Requests launched at rising edge, strobe one cycle
// Notes: Shares select, direction and data lines between the two ports
module lhsd_host_model (
  input wire logic i_clk,
  output logic o_sel,
  output logic [1:0] o_stb,
  output logic o_rs,
  output logic o_rd,
  output logic [7:0] o_d
);
  initial
  begin
    o_sel = 1'b1;
    o_stb = 2'h0;
    o_rs = 1'b0;
    o_rd = 1'b0;
    o_d = 8'h00;
  end
  // Bit 1 strobes the parallel port, bit 0 the serial one
  task automatic access(input logic s, input logic [1:0] p, input logic rs, input logic rd,
    input logic [7:0] d);
    @(posedge i_clk);
    o_sel <= s;
    o_stb <= p;
    o_rs <= rs;
    o_rd <= rd;
    o_d <= d;
    @(posedge i_clk);
    o_stb <= 2'h0;
    o_d <= ~d; // Released lines must not keep stale data
  endtask
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for the host-select block
// Assumes: Shortened power-on count of 4
// Notes: Power-on reset checks first, then table rows, then geometry, config and pin reset cases
module testbench import lhsd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic s; logic rs; logic rd; logic [7:0] d; logic [2:0] pul;
    logic [7:0] ev;} lhsd_row_t;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ext_n = 1'b1;
  logic sel, rs, rd, cv, dw, dr, pm, cr;
  logic [1:0] stb;
  logic [7:0] d, cd, dh, rdd;
  lhsd_cfg_t cfg;
  lhsd_geom_t geom;
  int error_cnt = 0;
  int num_checks = 0;
  lhsd_row_t rows [6] = '{'{1'b0, 1'b1, 1'b0, 8'h5A, 3'h2, 8'h5A}, '{1'b1, 1'b1, 1'b1, 8'h00, 3'h1, 8'h5A},
    '{1'b1, 1'b1, 1'b1, 8'h00, 3'h1, 8'hC3}, '{1'b0, 1'b0, 1'b1, 8'h00, 3'h0, 8'hA5},
    '{1'b1, 1'b0, 1'b0, 8'h2C, 3'h4, 8'h2C}, '{1'b0, 1'b0, 1'b0, 8'h0D, 3'h4, 8'h0D}};
  always #20 i_clk = ~i_clk;
  lhsd_host_model lhsd_host_model_inst (.i_clk(i_clk), .o_sel(sel), .o_stb(stb), .o_rs(rs), .o_rd(rd),
    .o_d(d));
  lhsd_host_select #(.POR_COUNT(4)) lhsd_host_select_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ext_reset_n(ext_n), .i_interface_select(sel), .i_par_strobe(stb[1]), .i_par_register_select(rs),
    .i_par_read(rd), .i_par_data(d), .i_ser_strobe(stb[0]), .i_ser_register_select(rs),
    .i_ser_read(rd), .i_ser_data(d), .i_busy(1'b1), .i_addr_counter(7'h25), .i_ram_rdata(8'hC3),
    .o_cmd_valid(cv), .o_cmd_data(cd), .o_data_wr(dw), .o_data_rd(dr), .o_data_hold(dh),
    .o_rd_data(rdd), .o_parallel_mode(pm), .o_core_reset(cr), .o_cfg(cfg), .o_geom(geom));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge i_clk);
    chk(geom, {DUTY_2LINE, 3'h2, CHARS_WIDE, ICON_MAX});
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(21'(cr), 21'h1);
    repeat (6) @(posedge i_clk);
    foreach (rows[i])
    begin
      lhsd_host_model_inst.access(rows[i].s, rows[i].s ? 2'h2 : 2'h1, rows[i].rs, rows[i].rd,
        rows[i].d);
      @(negedge i_clk);
      chk(21'(pm), 21'(rows[i].s));
      chk(21'({cv, dw, dr}), 21'(rows[i].pul));
      chk(21'(rows[i].rd ? rdd : rows[i].rs ? dh : cd), 21'(rows[i].ev));
    end
    settle();
    chk(geom, {DUTY_4LINE, 3'h4, CHARS_NARROW, ICON_MAX});
    // Strobe on the unselected port must be ignored
    lhsd_host_model_inst.access(1'b1, 2'h1, 1'b1, 1'b0, 8'h77);
    @(negedge i_clk);
    chk(21'({cv, dw, dr}), 21'h0);
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b0, 1'b0, 8'h09);
    settle();
    chk(geom, {DUTY_4LINE, 3'h4, CHARS_WIDE, ICON_MAX});
    // Segment direction, then reverse and per-line shift with their enables
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b0, 1'b0, 8'h07);
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b0, 1'b0, 8'h33);
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b0, 1'b0, 8'h34);
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b0, 1'b0, 8'h15);
    @(negedge i_clk);
    chk(21'(cfg), 21'(10'h2F5));
    @(posedge i_clk);
    ext_n <= 1'b0;
    lhsd_host_model_inst.access(1'b1, 2'h2, 1'b1, 1'b0, 8'h33);
    @(negedge i_clk);
    chk(21'({cv, dw, dr, cr}), 21'h1);
    chk(21'(cfg), 21'(10'h080));
    settle();
    chk(geom, {DUTY_2LINE, 3'h2, CHARS_WIDE, ICON_MAX});
    conclude();
  end
endmodule
